//--- design/pbpu_top.sv
// Overview of operation
// - Pullup control register lives at offset 30F1h, 8 bits, read and write.
// - Bit n of the register controls only the pullup of pin n.
// - Bit set enables the pin pullup; bit clear disables it.
// - Pins driven as outputs or held Hi-Z ignore the bit; pullup off.
`timescale 1ns/1ns
module pbpu_top (
    input  wire logic                         clock,
    input  wire logic                         arst_n,
    input  wire logic                         clk_en,
    input  wire logic [pbpu_pkg::ADDR_W-1:0]  addr,
    input  wire logic [pbpu_pkg::DATA_W-1:0]  wdata,
    input  wire logic                         wr_stb,
    input  wire logic                         rd_stb,
    output logic      [pbpu_pkg::DATA_W-1:0]  rdata,
    input  wire logic [pbpu_pkg::PIN_COUNT-1:0] pin_is_output,
    input  wire logic [pbpu_pkg::PIN_COUNT-1:0] pin_is_hiz,
    output logic      [pbpu_pkg::PIN_COUNT-1:0] pullup_active,
    output logic      [pbpu_pkg::PIN_COUNT-1:0] pullup_control
);
    ////////////////////////////////////////////////////////////////////////////
    logic [pbpu_pkg::DATA_W-1:0] next_pullup_control;
    logic [pbpu_pkg::DATA_W-1:0] next_rdata;
    logic                        hit;

    assign hit = (addr == pbpu_pkg::PULLUP_CTRL_OFF);

    always_comb
    begin
        next_pullup_control = pullup_control;
        next_rdata          = rdata;
        if (wr_stb && hit)
        begin
            next_pullup_control = wdata;
        end
        // Read data held only one cycle; otherwise zero
        if (rd_stb)
        begin
            next_rdata = hit ? pullup_control : pbpu_pkg::UNMAPPED_READ;
        end
        else
        begin
            next_rdata = '0;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pullup_control <= pbpu_pkg::PULLUP_CTRL_RST;
            rdata          <= '0;
        end
        else if (clk_en)
        begin
            pullup_control <= next_pullup_control;
            rdata          <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One cell per pin keeps each bit tied to its own pin
    for (genvar i = 0; i < pbpu_pkg::PIN_COUNT; i++)
    begin : g_pin
        pbpu_pin_pull u_pull (
            .enable_bit (pullup_control[i]),
            .drive_out  (pin_is_output[i]),
            .hi_z       (pin_is_hiz[i]),
            .pull_on    (pullup_active[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    write_lands_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && wr_stb && hit |=> pullup_control == $past(wdata))
        else $error("write to pullup register lost");
    read_back_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && rd_stb && hit |=> rdata == $past(pullup_control))
        else $error("read data wrong");
    other_addr_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && wr_stb && !hit |=> $stable(pullup_control))
        else $error("foreign write changed register");
    bit_map_a: assert property (@(posedge clock) disable iff (!arst_n)
        pullup_active == (pullup_control & ~pin_is_output & ~pin_is_hiz))
        else $error("pullup mapping wrong");
    on_input_a: assert property (@(posedge clock) disable iff (!arst_n)
        pullup_control[0] && !pin_is_output[0] && !pin_is_hiz[0] |-> pullup_active[0])
        else $error("pullup not enabled");
    off_output_a: assert property (@(posedge clock) disable iff (!arst_n)
        (pullup_active & (pin_is_output | pin_is_hiz)) == '0)
        else $error("pullup active on output or hiz");
    reset_zero_a: assert property (@(posedge clock)
        !arst_n |-> pullup_control == '0)
        else $error("register not zero in reset");
    rdata_idle_a: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && !rd_stb |=> rdata == '0)
        else $error("read data not cleared");
    ctrl_write_c: cover property (@(posedge clock) disable iff (!arst_n)
        clk_en && wr_stb && hit ##1 clk_en && rd_stb && hit);
    pull_on_c: cover property (@(posedge clock) disable iff (!arst_n) pullup_active == 8'hff);
    masked_c: cover property (@(posedge clock) disable iff (!arst_n)
        pullup_control[1] && pin_is_output[1]);
endmodule : pbpu_top

//--- design/pbpu_pkg.sv
package pbpu_pkg;
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 8;
    localparam int          PIN_COUNT       = 8;
    localparam logic [15:0] PULLUP_CTRL_OFF = 16'h30f1;
    localparam logic [7:0]  PULLUP_CTRL_RST = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ   = 8'h00;
endpackage : pbpu_pkg

//--- design/pbpu_pin_pull.sv
`timescale 1ns/1ns
module pbpu_pin_pull (
    input  wire logic enable_bit,
    input  wire logic drive_out,
    input  wire logic hi_z,
    output logic      pull_on
);
    // Pullup only for a true input; output or Hi-Z ignores the bit
    assign pull_on = enable_bit & ~drive_out & ~hi_z;
endmodule : pbpu_pin_pull

//--- test/test_port_b_pullup_enable.sv
`timescale 1ns/1ns
module test_port_b_pullup_enable;
    logic        clock  = 1'b0;
    logic        arst_n;
    logic        clk_en = 1'b1;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic [15:0] addr   = 16'h0000;
    logic [7:0]  wdata  = 8'h00;
    logic [7:0]  p_out  = 8'h00;
    logic [7:0]  p_hiz  = 8'h00;
    logic [7:0]  rdata, act, ctl;
    int          n_fail = 0;
    int          n_compared = 0;
    localparam logic [15:0] OFF = pbpu_pkg::PULLUP_CTRL_OFF;
    always #2 clock = ~clock;
    pbpu_top u_dut (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pin_is_output(p_out),
        .pin_is_hiz(p_hiz), .pullup_active(act), .pullup_control(ctl));
    task cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (e !== g) $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        n_fail += int'(e !== g);
    endtask : cmp
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
        #1;
    endtask : wr
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clock);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 cmp("rdata", e, rdata);
    endtask : rd
    task pins(input logic [7:0] c, input logic [7:0] o, input logic [7:0] z);
        wr(OFF, c);
        p_out <= o;
        p_hiz <= z;
        cmp("pullup_control", c, ctl);
        #1 cmp("pullup_active", c & ~o & ~z, act);
    endtask : pins
    task print_verdict;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        // Unknown to low gives the reset flops a real falling edge
        arst_n <= 1'b0;
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        rd(OFF, 8'h00);
        wr(OFF, 8'ha5);
        rd(OFF, 8'ha5);
        wr(16'h30f0, 8'hff);
        rd(16'h30f0, 8'h00);
        clk_en <= 1'b0;
        wr(OFF, 8'h3c);
        clk_en <= 1'b1;
        rd(OFF, 8'ha5);
        for (int i = 0; i < 8; i++) pins(8'h01 << i, 8'h00, 8'h00);
        for (int i = 0; i < 8; i++) pins(8'hff, 8'h01 << i, 8'h80 >> i);
        pins(8'h5a, 8'h0f, 8'h30);
        print_verdict();
    end
    initial
    begin
        #4000 n_fail++;
        print_verdict();
    end
endmodule : test_port_b_pullup_enable
